// >>> csp_pkg.sv
package csp_pkg;
   // Clock rate in MHz
   localparam int CLK_MHZ = 125;
   // Interrupt pulse width, microseconds
   localparam int INT_PULSE_US = 256;
   // Cycles of interrupt pulse; exact at 125 MHz
   localparam int INT_PULSE_CYC = INT_PULSE_US * CLK_MHZ;
   // Widths of the charge-current code and voltage codes
   localparam int ILIM_W = 8;
   localparam int VOLT_W = 12;
   localparam int STATE_W = 3;
   // Reset value of the charge-state encoding table: each entry {a, b}
   localparam logic [15:0] STATE_MAP_RST = 16'h1B00;

   // Software control bits
   typedef struct packed {
      logic state_pins_off;
      logic state_a_manual;
      logic state_b_manual;
      logic good_pin_off;
      logic good_pin_manual;
      logic allow_pin_off;
      logic allow_pin_manual;
      logic charge_permit;
      logic charge_limit_pin_use;
   } csp_ctrl_s;

   // Open-drain pin drive: high enable pulls the line low
   typedef struct packed {
      logic int_oe;
      logic state_a_oe;
      logic state_b_oe;
      logic good_oe;
      logic allow_oe;
   } csp_od_s;
endpackage : csp_pkg

// >>> csp_sync.sv
`timescale 1ns/100ps
// Two-flop synchroniser, one per bit
module csp_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Data
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] s1_r;
   logic [W-1:0] s2_r;

   // First stage feeds only the second
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s1_r <= '0;
         s2_r <= '0;
      end else begin
         s1_r <= d;
         s2_r <= s1_r;
      end
   end
   assign q = s2_r;
endmodule : csp_sync

// >>> csp_status_pins.sv
`timescale 1ns/100ps
// Functional notes
// - Status changes and faults pull the interrupt line low for one 256 us pulse.
// - With the status-pin disable set, charger state no longer drives the two status pins.
// - While status pins are disabled each follows its own manual force bit.
// - Power-good is pulled low only while input voltage lies inside the window.
// - With the power-good disable set, power-good follows its manual force bit.
// - Charging is enabled only with charge permit set and the enable pin sampled low.
// - The enable pin must be held at a defined level; the device never depends on a float.
// - With the enable-pin disable set, the pin is ignored and driven from its force bit.
// - Charging is suspended while the thermistor reading is outside the window.
// - The effective charge limit is the smaller of pin and register limits.
// - With pin-use cleared, only the register limit applies.
module csp_status_pins #(
   parameter int PULSE_CYC = csp_pkg::INT_PULSE_CYC,
   parameter logic [15:0] STATE_MAP = csp_pkg::STATE_MAP_RST
) (
   // Clock and reset
   input wire logic SYS_CLK,
   input wire logic RESET,
   // Software control
   input wire csp_pkg::csp_ctrl_s CTRL,
   input wire logic [csp_pkg::ILIM_W-1:0] CHARGE_LIMIT_SETTING,
   // Charger core state and event request
   input wire logic [csp_pkg::STATE_W-1:0] CHARGE_STATE,
   input wire logic STATUS_EVENT,
   // Analog comparator results, asynchronous
   input wire logic [csp_pkg::VOLT_W-1:0] INPUT_VOLTAGE,
   input wire logic [csp_pkg::VOLT_W-1:0] INPUT_UNDERVOLT_BOUND,
   input wire logic [csp_pkg::VOLT_W-1:0] INPUT_OVERVOLT_BOUND,
   input wire logic THERMISTOR_SENSE_OK,
   input wire logic [csp_pkg::ILIM_W-1:0] CHARGE_LIMIT_PIN,
   // Charge-enable pin, two-way
   input wire logic ALLOW_PIN_I,
   // Open-drain outputs
   output csp_pkg::csp_od_s OD_OE,
   output logic INPUT_GOOD_N,
   // Charger gating results
   output logic CHARGE_ENABLE,
   output logic [csp_pkg::ILIM_W-1:0] CHARGE_LIMIT_EFF
);
   localparam int CW = $clog2(PULSE_CYC + 1);
   localparam logic [CW-1:0] PULSE_LAST = CW'(PULSE_CYC - 1);

   logic allow_pin_s;
   logic therm_ok_s;
   logic [CW-1:0] cnt_r;
   logic [CW-1:0] cnt_nxt;
   logic busy_r;
   logic busy_nxt;
   logic pend_r;
   logic pend_nxt;
   logic win_ok;
   logic [1:0] map_ab;
   csp_pkg::csp_od_s od_r;
   csp_pkg::csp_od_s od_nxt;
   logic en_r;
   logic en_nxt;
   logic [csp_pkg::ILIM_W-1:0] lim_r;
   logic [csp_pkg::ILIM_W-1:0] lim_nxt;

   // Enable-pin and thermistor levels pass two flops; the enable pin resets high (charging off)
   csp_sync #(.W(2)) u_sync (
      .clk(SYS_CLK),
      .rst(RESET),
      .d({~ALLOW_PIN_I, THERMISTOR_SENSE_OK}),
      .q({allow_pin_s, therm_ok_s})
   );

   // Interrupt pulse timer; an event during a pulse is held and sent afterwards
   always_comb begin
      cnt_nxt = cnt_r;
      busy_nxt = busy_r;
      pend_nxt = pend_r | STATUS_EVENT;
      if (busy_r) begin
         if (cnt_r == PULSE_LAST) begin
            // A held request restarts at once, so back-to-back pulses merge with no gap
            busy_nxt = pend_r | STATUS_EVENT;
            cnt_nxt = '0;
            pend_nxt = 1'b0;
         end else begin
            cnt_nxt = cnt_r + CW'(1);
         end
      end else if (pend_r | STATUS_EVENT) begin
         busy_nxt = 1'b1;
         cnt_nxt = '0;
         pend_nxt = 1'b0;
      end
   end

   always_ff @(posedge SYS_CLK or posedge RESET) begin
      if (RESET) begin
         cnt_r <= '0;
         busy_r <= 1'b0;
         pend_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         busy_r <= busy_nxt;
         pend_r <= pend_nxt;
      end
   end

   // Window compare and table lookup
   assign win_ok = (INPUT_VOLTAGE >= INPUT_UNDERVOLT_BOUND) &&
                   (INPUT_VOLTAGE <= INPUT_OVERVOLT_BOUND);
   assign map_ab = STATE_MAP[2*CHARGE_STATE +: 2];

   // Pin drive; force bits act directly so a write lands in one cycle
   always_comb begin
      od_nxt.int_oe = busy_nxt;
      od_nxt.state_a_oe = CTRL.state_pins_off ? CTRL.state_a_manual : map_ab[1];
      od_nxt.state_b_oe = CTRL.state_pins_off ? CTRL.state_b_manual : map_ab[0];
      od_nxt.good_oe = CTRL.good_pin_off ? CTRL.good_pin_manual : win_ok;
      od_nxt.allow_oe = CTRL.allow_pin_off & CTRL.allow_pin_manual;
   end

   // Charge gating; only the synchronised pin level is used
   always_comb begin
      en_nxt = CTRL.charge_permit & (CTRL.allow_pin_off | allow_pin_s) & therm_ok_s;
      lim_nxt = CHARGE_LIMIT_SETTING;
      if (CTRL.charge_limit_pin_use && CHARGE_LIMIT_PIN < CHARGE_LIMIT_SETTING) begin
         lim_nxt = CHARGE_LIMIT_PIN;
      end
   end

   always_ff @(posedge SYS_CLK or posedge RESET) begin
      if (RESET) begin
         od_r <= '0;
         en_r <= 1'b0;
         lim_r <= '0;
      end else begin
         od_r <= od_nxt;
         en_r <= en_nxt;
         lim_r <= lim_nxt;
      end
   end

   assign OD_OE = od_r;
   assign INPUT_GOOD_N = ~od_r.good_oe;
   assign CHARGE_ENABLE = en_r;
   assign CHARGE_LIMIT_EFF = lim_r;

   // Interrupt stays low for at least 8 cycles once started
   a_int_pulse_len: assert property (@(posedge SYS_CLK) disable iff (RESET)
      $rose(od_r.int_oe) |-> od_r.int_oe [*8]) else $error("Interrupt pulse too short");
   // Pulse counter never runs past its last count
   a_int_cnt_bound: assert property (@(posedge SYS_CLK) disable iff (RESET)
      busy_r |-> cnt_r <= PULSE_LAST) else $error("Interrupt counter overrun");
   // Interrupt ends exactly at the last count
   a_int_end: assert property (@(posedge SYS_CLK) disable iff (RESET)
      (busy_r && cnt_r == PULSE_LAST && !pend_r && !STATUS_EVENT) |=> !od_r.int_oe)
      else $error("Interrupt pulse end wrong");
   // Disabled status pins follow force bits
   a_state_force: assert property (@(posedge SYS_CLK) disable iff (RESET)
      CTRL.state_pins_off |=> (od_r.state_a_oe == $past(CTRL.state_a_manual)) &&
      (od_r.state_b_oe == $past(CTRL.state_b_manual))) else $error("Status force wrong");
   // Enabled status pin A follows the table
   a_state_map: assert property (@(posedge SYS_CLK) disable iff (RESET)
      !CTRL.state_pins_off |=> od_r.state_a_oe == $past(map_ab[1]))
      else $error("Status map wrong");
   // Power-good follows window when enabled
   a_good_window: assert property (@(posedge SYS_CLK) disable iff (RESET)
      !CTRL.good_pin_off |=> INPUT_GOOD_N == !$past(win_ok)) else $error("Power-good wrong");
   // Power-good force
   a_good_force: assert property (@(posedge SYS_CLK) disable iff (RESET)
      CTRL.good_pin_off |=> od_r.good_oe == $past(CTRL.good_pin_manual))
      else $error("Power-good force wrong");
   // No permit means no charging
   a_charge_permit: assert property (@(posedge SYS_CLK) disable iff (RESET)
      !CTRL.charge_permit |=> !CHARGE_ENABLE) else $error("Charging without permit");
   // Enable pin only driven when handed to software
   a_allow_drive: assert property (@(posedge SYS_CLK) disable iff (RESET)
      !CTRL.allow_pin_off |=> !od_r.allow_oe) else $error("Enable pin driven");
   // Thermistor fault suspends charging
   a_therm_suspend: assert property (@(posedge SYS_CLK) disable iff (RESET)
      !therm_ok_s |=> !CHARGE_ENABLE) else $error("Charging with thermistor fault");
   // Limit never above register setting
   a_limit_min: assert property (@(posedge SYS_CLK) disable iff (RESET)
      ##1 CHARGE_LIMIT_EFF <= $past(CHARGE_LIMIT_SETTING)) else $error("Limit too high");
   // Pin limit ignored when unused
   a_limit_reg: assert property (@(posedge SYS_CLK) disable iff (RESET)
      !CTRL.charge_limit_pin_use |=> CHARGE_LIMIT_EFF == $past(CHARGE_LIMIT_SETTING))
      else $error("Pin limit used");
endmodule : csp_status_pins

// >>> csp_host_model.sv
`timescale 1ns/100ps
// Host side of the pins: pull-ups on the open-drain lines, a held enable level
module csp_host_model (
   // Device drive
   input wire csp_pkg::csp_od_s od,
   input wire logic host_level,
   // Resolved wire levels
   output logic int_n,
   output logic state_a_n,
   output logic state_b_n,
   output logic allow_n
);
   // Pull-ups win unless the device pulls the line low
   assign int_n = ~od.int_oe;
   assign state_a_n = ~od.state_a_oe;
   assign state_b_n = ~od.state_b_oe;
   // Never left floating; a device pull-down overrides the host level
   assign allow_n = host_level & ~od.allow_oe;
endmodule : csp_host_model

// >>> charger_status_pin_logic_test.sv
`timescale 1ns/100ps
module charger_status_pin_logic_test;
   // Short pulse keeps the run brief
   localparam int PCYC = 16;
   // Vectors {permit, pin level, temp ok, pin off, expected enable}
   localparam logic [4:0] CE_VEC [6] = '{5'b10101, 5'b00100, 5'b11100, 5'b10000,
      5'b10101, 5'b11111};
   logic clk = 1'b0;
   logic rst = 1'b1;
   csp_pkg::csp_ctrl_s ctrl = '0;
   logic [7:0] lim_set = 8'h00;
   logic [7:0] lim_pin = 8'h00;
   logic [2:0] state = 3'h0;
   logic evt = 1'b0;
   logic [11:0] volt = 12'h000;
   logic [11:0] uv = 12'h100;
   logic [11:0] ov = 12'h800;
   logic temp_ok = 1'b1;
   logic host_level = 1'b1;
   csp_pkg::csp_od_s od;
   logic good_n, chg_en, int_n, sa_n, sb_n, allow_n;
   logic [7:0] lim_eff;
   int failures = 0;
   int checks_done = 0;
   int n;

   csp_status_pins #(.PULSE_CYC(PCYC)) u_csp_status_pins (.SYS_CLK(clk), .RESET(rst),
      .CTRL(ctrl), .CHARGE_LIMIT_SETTING(lim_set), .CHARGE_STATE(state), .STATUS_EVENT(evt),
      .INPUT_VOLTAGE(volt), .INPUT_UNDERVOLT_BOUND(uv), .INPUT_OVERVOLT_BOUND(ov),
      .THERMISTOR_SENSE_OK(temp_ok), .CHARGE_LIMIT_PIN(lim_pin), .ALLOW_PIN_I(allow_n),
      .OD_OE(od), .INPUT_GOOD_N(good_n), .CHARGE_ENABLE(chg_en), .CHARGE_LIMIT_EFF(lim_eff));
   csp_host_model u_csp_host_model (.od(od), .host_level(host_level), .int_n(int_n),
      .state_a_n(sa_n), .state_b_n(sb_n), .allow_n(allow_n));

   // 8 ns clock
   always #4 clk = ~clk;

   // Inputs always move 1 ns after an edge, so no race with the design
   task automatic step(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask : step

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic close_out;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : close_out

   // Main sequence
   initial begin
      step(20);
      chk("reset drive", 16'h0001, {10'h0, od, good_n});
      rst = 1'b0;
      // Both bounds inside, one code beyond each outside
      for (int i = 0; i < 4; i++) begin
         volt = (i == 0) ? uv : (i == 1) ? ov : (i == 2) ? uv - 12'h001 : ov + 12'h001;
         step(4);
         chk("input_good_n", {15'h0, i > 1}, {15'h0, good_n});
      end
      ctrl.good_pin_off = 1'b1;
      for (int i = 0; i < 2; i++) begin
         ctrl.good_pin_manual = i[0];
         volt = i[0] ? 12'h000 : uv;
         step(1);
         chk("good forced", {15'h0, ~i[0]}, {15'h0, good_n});
      end
      for (int s = 0; s < 8; s++) begin
         state = s[2:0];
         step(1);
         chk("state pins", {14'h0, csp_pkg::STATE_MAP_RST[2*s+:2]}, {14'h0, ~sa_n, ~sb_n});
      end
      // State 4 would pull both pins; the manual bits must win
      state = 3'h4;
      ctrl.state_pins_off = 1'b1;
      for (int m = 0; m < 4; m++) begin
         {ctrl.state_a_manual, ctrl.state_b_manual} = m[1:0];
         step(1);
         chk("state forced", {14'h0, m[1:0]}, {14'h0, ~sa_n, ~sb_n});
      end
      foreach (CE_VEC[v]) begin
         {ctrl.charge_permit, host_level, temp_ok, ctrl.allow_pin_off} = CE_VEC[v][4:1];
         step(4);
         chk("charge_enable", {15'h0, CE_VEC[v][0]}, {15'h0, chg_en});
      end
      ctrl.allow_pin_manual = 1'b1;
      step(1);
      chk("allow pin", 16'h0000, {15'h0, allow_n});
      for (int k = 0; k < 3; k++) begin
         lim_pin = 8'h40;
         lim_set = k[0] ? 8'h30 : 8'h50;
         ctrl.charge_limit_pin_use = (k < 2);
         step(1);
         chk("limit", {8'h0, (k < 2 && lim_pin < lim_set) ? lim_pin : lim_set},
            {8'h0, lim_eff});
      end
      // Second pass adds an event mid-pulse; the pending pulse follows with no gap
      for (int e = 0; e < 2; e++) begin
         evt = 1'b1;
         step(1);
         n = 0;
         while (int_n === 1'b0 && n < 100) begin
            evt = (e == 1 && n == 3);
            step(1);
            n++;
         end
         chk("int pulse", 16'((e + 1) * PCYC), 16'(n));
      end
      close_out();
   end

   // Watchdog: the tests need well under 1000 cycles
   initial begin
      #100000;
      failures++;
      close_out();
   end
endmodule : charger_status_pin_logic_test
